/* bcc_ctrl.sv */
/*
 Buck channel configuration and control: register file, run/standby
 mode selection, discharge-and-restart on voltage change, interrupt.
 Assumes OTP defaults are stable on core_clk from reset onward, and the
 standby and system-on pins are asynchronous.
*/
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "bcc_cfg.svh"
module bcc_ctrl #(
   parameter int unsigned DISCH_CYCLES = `BCC_DISCH_US * `BCC_CLK_MHZ
) (
   input logic core_clk, // Core clock, 25 MHz
   input logic rst_b, // Async reset, active low
   input logic [3:0] regAddr, // Register address
   input logic [7:0] regWdata, // Write data
   input logic regWr, // Write strobe
   input logic regRd, // Read strobe
   output logic [7:0] regRdata, // Read data, cycle after strobe
   input logic [4:0] otpOutVoltageDefault, // OTP voltage code
   input logic [2:0] otpPhaseDefault, // OTP phase code
   input logic [1:0] otpInductorSel, // OTP inductor code
   input logic otpInPowerUpSeq, // Channel is in power-up sequence
   input logic standbyPin, // High in standby state
   input logic systemOnPin, // High in system-on states
   output logic regEnable, // Regulator enabled
   output logic dischargeEn, // Output discharge active
   output bcc_pkg::bcc_mode_t regulatorModeCode, // Active mode
   output logic [2:0] modeSelect, // {autoskip, pfm, pwm}
   output logic [12:0] setpointMv, // Set point in mV
   output logic [12:0] currentLimitMa, // Peak limit in mA
   output logic [8:0] phaseDeg, // Phase shift in degrees
   output logic [10:0] inductorNh, // Inductor in nH
   output logic inductorReserved, // Reserved inductor code
   output logic irqOutN // Interrupt, active low
);
   import bcc_pkg::*;

   localparam logic [15:0] DISCH_LAST = 16'(DISCH_CYCLES - 1);

   // ----------------------------------------
   // Pin inputs
   // ----------------------------------------
   logic [1:0] pinLevel;
   logic standbyNow, sysOn;

   bcc_sync #(
      .W(2)
   ) u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .pinIn({systemOnPin, standbyPin}),
      .levelOut(pinLevel)
   );

   assign standbyNow = pinLevel[0];
   assign sysOn = pinLevel[1];

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic initDone_reg, initDone_next;
   logic [4:0] voltCode_reg, voltCode_next;
   bcc_mode_t runMode_reg, runMode_next;
   bcc_mode_t stbyMode_reg, stbyMode_next;
   logic [1:0] ilimSel_reg, ilimSel_next;
   logic [2:0] phaseSel_reg, phaseSel_next;
   logic [1:0] lsel_reg, lsel_next;
   logic [1:0] irqMask_reg, irqMask_next;
   logic hostWr;

   assign hostWr = regWr && initDone_reg;

   // OTP load on the first edge after reset, host writes afterwards
   always_comb begin
      initDone_next = 1'b1;
      voltCode_next = voltCode_reg;
      runMode_next = runMode_reg;
      stbyMode_next = stbyMode_reg;
      ilimSel_next = ilimSel_reg;
      phaseSel_next = phaseSel_reg;
      lsel_next = lsel_reg;
      irqMask_next = irqMask_reg;
      if (!initDone_reg) begin
         voltCode_next = otpOutVoltageDefault;
         runMode_next = otpInPowerUpSeq ? MODE_AUTOSKIP : MODE_OFF;
         stbyMode_next = otpInPowerUpSeq ? MODE_AUTOSKIP : MODE_OFF;
         phaseSel_next = otpPhaseDefault;
         lsel_next = otpInductorSel;
      end else if (hostWr) begin
         case (regAddr)
            `BCC_ADDR_VOLT: begin
               voltCode_next = regWdata[`BCC_VOLT_CODE];
            end
            `BCC_ADDR_MODE: begin
               runMode_next = bcc_mode_t'(regWdata[`BCC_MODE_RUN]);
               stbyMode_next = bcc_mode_t'(regWdata[`BCC_MODE_STBY]);
            end
            `BCC_ADDR_CFG: begin
               ilimSel_next = regWdata[`BCC_CFG_ILIM];
               phaseSel_next = regWdata[`BCC_CFG_PHASE];
            end
            `BCC_ADDR_IRQ_MASK: begin
               irqMask_next = regWdata[`BCC_IRQ_BITS];
            end
            default: begin
            end
         endcase
      end
   end

   // Configuration state
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         initDone_reg <= 1'b0;
         voltCode_reg <= `BCC_VOLT_RST;
         runMode_reg <= MODE_OFF;
         stbyMode_reg <= MODE_OFF;
         ilimSel_reg <= `BCC_ILIM_RST;
         phaseSel_reg <= `BCC_PHASE_RST;
         lsel_reg <= `BCC_LSEL_RST;
         irqMask_reg <= `BCC_MASK_RST;
      end else begin
         initDone_reg <= initDone_next;
         voltCode_reg <= voltCode_next;
         runMode_reg <= runMode_next;
         stbyMode_reg <= stbyMode_next;
         ilimSel_reg <= ilimSel_next;
         phaseSel_reg <= phaseSel_next;
         lsel_reg <= lsel_next;
         irqMask_reg <= irqMask_next;
      end
   end

   // ----------------------------------------
   // Mode selection and output sequencer
   // ----------------------------------------
   bcc_state_t state_reg, state_next;
   bcc_mode_t activeMode_reg, activeMode_next;
   logic [4:0] appliedCode_reg, appliedCode_next;
   logic [15:0] dischCnt_reg, dischCnt_next;
   logic enable_reg, enable_next, disch_reg, disch_next;
   logic wantOn, codeChange, modeEvt, restartEvt;

   // Sequencer; a new code while enabled forces a discharge first
   always_comb begin
      activeMode_next = standbyNow ? stbyMode_reg : runMode_reg;
      wantOn = initDone_reg && sysOn && (activeMode_reg != MODE_OFF);
      codeChange = (voltCode_reg != appliedCode_reg);
      modeEvt = initDone_reg && (activeMode_next != activeMode_reg);
      restartEvt = 1'b0;
      state_next = state_reg;
      appliedCode_next = appliedCode_reg;
      dischCnt_next = 16'h0000;
      case (state_reg)
         ST_OFF: begin
            appliedCode_next = voltCode_reg;
            if (wantOn) begin
               state_next = ST_ON;
            end
         end
         ST_ON: begin
            if (!wantOn) begin
               state_next = ST_OFF;
            end else if (codeChange) begin
               state_next = ST_DISCH;
            end
         end
         ST_DISCH: begin
            dischCnt_next = dischCnt_reg + 16'h0001;
            if (dischCnt_reg == DISCH_LAST) begin
               dischCnt_next = 16'h0000;
               appliedCode_next = voltCode_reg;
               restartEvt = wantOn;
               state_next = wantOn ? ST_ON : ST_OFF;
            end
         end
         default: begin
            state_next = ST_OFF;
         end
      endcase
      enable_next = (state_next == ST_ON);
      disch_next = (state_next == ST_DISCH);
   end

   // Sequencer state
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_OFF;
         activeMode_reg <= MODE_OFF;
         appliedCode_reg <= `BCC_VOLT_RST;
         dischCnt_reg <= 16'h0000;
         enable_reg <= 1'b0;
         disch_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         activeMode_reg <= activeMode_next;
         appliedCode_reg <= appliedCode_next;
         dischCnt_reg <= dischCnt_next;
         enable_reg <= enable_next;
         disch_reg <= disch_next;
      end
   end

   assign regEnable = enable_reg;
   assign dischargeEn = disch_reg;
   assign regulatorModeCode = activeMode_reg;

   // ----------------------------------------
   // Interrupt and read port
   // ----------------------------------------
   logic [1:0] irqStat_reg, irqStat_next, irqClr;
   logic [7:0] rdata_reg, rdata_next;

   // Sticky events, write one to clear, a new event beats the clear
   always_comb begin
      irqClr = (hostWr && regAddr == `BCC_ADDR_IRQ_STAT) ? regWdata[`BCC_IRQ_BITS] : 2'h0;
      irqStat_next = (irqStat_reg & ~irqClr) | {restartEvt, modeEvt};
      rdata_next = 8'h00;
      if (regRd) begin
         case (regAddr)
            `BCC_ADDR_VOLT: rdata_next = {3'h0, voltCode_reg};
            `BCC_ADDR_MODE: rdata_next = {4'h0, stbyMode_reg, runMode_reg};
            `BCC_ADDR_CFG: rdata_next = {3'h0, phaseSel_reg, ilimSel_reg};
            `BCC_ADDR_STATUS: begin
               rdata_next = {1'b0, lsel_reg, standbyNow, disch_reg, enable_reg,
                             activeMode_reg};
            end
            `BCC_ADDR_IRQ_STAT: rdata_next = {6'h00, irqStat_reg};
            `BCC_ADDR_IRQ_MASK: rdata_next = {6'h00, irqMask_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // Interrupt and read data state
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_reg <= `BCC_IRQ_RST;
         rdata_reg <= 8'h00;
      end else begin
         irqStat_reg <= irqStat_next;
         rdata_reg <= rdata_next;
      end
   end

   assign regRdata = rdata_reg;
   assign irqOutN = ~|(irqStat_reg & ~irqMask_reg);

   // ----------------------------------------
   // Decode of applied settings
   // ----------------------------------------
   bcc_decode u_decode (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .voltCode(appliedCode_reg),
      .ilimSel(ilimSel_reg),
      .phaseSel(phaseSel_reg),
      .inductorSel(lsel_reg),
      .modeCode(activeMode_reg),
      .setpointMv(setpointMv),
      .currentLimitMa(currentLimitMa),
      .phaseDeg(phaseDeg),
      .inductorNh(inductorNh),
      .inductorReserved(inductorReserved),
      .modeSelect(modeSelect)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   volt_load_a: assert property ($rose(initDone_reg) |->
         voltCode_reg == $past(otpOutVoltageDefault))
      else $error("voltage code not loaded from OTP");
   mode_load_a: assert property ($rose(initDone_reg) |->
         runMode_reg == ($past(otpInPowerUpSeq) ? MODE_AUTOSKIP : MODE_OFF) &&
         stbyMode_reg == runMode_reg)
      else $error("mode fields not loaded from sequence strap");
   phase_load_a: assert property ($rose(initDone_reg) |->
         phaseSel_reg == $past(otpPhaseDefault))
      else $error("phase not loaded from OTP");
   disch_start_a: assert property (state_reg == ST_ON && wantOn && codeChange |=>
         dischargeEn && !regEnable)
      else $error("code change did not discharge first");
   disch_hold_a: assert property (state_reg == ST_DISCH &&
         dischCnt_reg != DISCH_LAST |=> state_reg == ST_DISCH)
      else $error("discharge ended early");
   restart_code_a: assert property (state_reg == ST_DISCH ##1
         state_reg == ST_ON |-> appliedCode_reg == $past(voltCode_reg))
      else $error("restart not at new code");
   mode_follow_a: assert property (initDone_reg |=>
         activeMode_reg == ($past(standbyNow) ? $past(stbyMode_reg) : $past(runMode_reg)))
      else $error("active mode not following state");
   mode_irq_a: assert property ($changed(activeMode_reg) && $past(initDone_reg) |->
         irqStat_reg[0])
      else $error("mode change did not flag interrupt");
   irq_pin_a: assert property (irqStat_reg[0] && !irqMask_reg[0] |-> !irqOutN)
      else $error("unmasked flag not on pin");
   set_wins_a: assert property (modeEvt && irqClr[0] |=> irqStat_reg[0])
      else $error("clear beat a new event");
   stby_volt_a: assert property (state_reg == ST_ON && $changed(standbyNow) &&
         !codeChange |=> $stable(appliedCode_reg))
      else $error("standby toggle moved voltage");
   off_mode_a: assert property (activeMode_reg == MODE_OFF |=> !regEnable)
      else $error("off mode left regulator on");

   restart_c: cover property (state_reg == ST_DISCH ##1 state_reg == ST_ON);
   mode_irq_c: cover property ($fell(irqOutN));
   stby_c: cover property (state_reg == ST_ON && $rose(standbyNow));
endmodule

/* bcc_cfg.svh */
/*
 Constants for the buck channel configuration block: register offsets,
 field ranges, reset values and timing figures.
 Assumes it is included by its bare name from every file that needs it.
*/
`ifndef BCC_CFG_SVH
`define BCC_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BCC_ADDR_VOLT 4'h0
`define BCC_ADDR_MODE 4'h1
`define BCC_ADDR_CFG 4'h2
`define BCC_ADDR_STATUS 4'h3
`define BCC_ADDR_IRQ_STAT 4'h4
`define BCC_ADDR_IRQ_MASK 4'h5

// ----------------------------------------
// Field ranges
// ----------------------------------------
`define BCC_VOLT_CODE 4:0
`define BCC_MODE_RUN 1:0
`define BCC_MODE_STBY 3:2
`define BCC_CFG_ILIM 1:0
`define BCC_CFG_PHASE 4:2
`define BCC_IRQ_BITS 1:0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BCC_VOLT_RST 5'h00
`define BCC_ILIM_RST 2'h0
`define BCC_PHASE_RST 3'h0
`define BCC_LSEL_RST 2'h0
`define BCC_IRQ_RST 2'h0
`define BCC_MASK_RST 2'h0

// ----------------------------------------
// Decode figures
// ----------------------------------------
`define BCC_VCODE_TOP 5'h1a
`define BCC_VMAX_MV 13'h1004
`define BCC_PHASE_STEP 9'h02d
`define BCC_PHASE_ZERO 3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define BCC_CLK_MHZ 25
`define BCC_DISCH_US 200

`endif

/* bcc_pkg.sv */
/*
 Types shared by the buck channel configuration block.
 Assumes nothing of its surroundings.
*/
package bcc_pkg;
   // Regulator operating mode
   typedef enum logic [1:0] {
      MODE_OFF = 2'h0,
      MODE_PWM = 2'h1,
      MODE_PFM = 2'h2,
      MODE_AUTOSKIP = 2'h3
   } bcc_mode_t;

   // Output sequencer states, Gray along off-on-discharge
   typedef enum logic [1:0] {
      ST_OFF = 2'h0,
      ST_ON = 2'h1,
      ST_DISCH = 2'h3
   } bcc_state_t;
endpackage

/* bcc_sync.sv */
/*
 Pin input filter: three stage flip-flops and a level register, a change is taken once the
 second and third stages agree.
 Assumes inputs are asynchronous to core_clk.
*/
`timescale 1ns/100ps
module bcc_sync #(
   parameter int W = 1
) (
   input logic core_clk, // Core clock
   input logic rst_b, // Async reset, active low
   input logic [W-1:0] pinIn, // Raw pin levels
   output logic [W-1:0] levelOut // Filtered levels
);
   logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;

   // Keep the level unless the last two stages agree
   always_comb begin
      lvl_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & lvl_reg);
   end

   // Stage registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         lvl_reg <= '0;
      end else begin
         s1_reg <= pinIn;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         lvl_reg <= lvl_next;
      end
   end

   assign levelOut = lvl_reg;
endmodule

/* bcc_decode.sv */
/*
 Registered decode of the applied codes into set point, current limit,
 phase shift, inductor value and one-hot mode selects.
 Assumes codes come from logic on core_clk.
*/
`timescale 1ns/100ps
`include "bcc_cfg.svh"
module bcc_decode (
   input logic core_clk, // Core clock
   input logic rst_b, // Async reset, active low
   input logic [4:0] voltCode, // Applied voltage code
   input logic [1:0] ilimSel, // Current limit select
   input logic [2:0] phaseSel, // Phase select
   input logic [1:0] inductorSel, // Inductor select
   input bcc_pkg::bcc_mode_t modeCode, // Active mode
   output logic [12:0] setpointMv, // Set point in mV
   output logic [12:0] currentLimitMa, // Peak limit in mA
   output logic [8:0] phaseDeg, // Phase shift in degrees
   output logic [10:0] inductorNh, // Inductor in nH
   output logic inductorReserved, // Reserved inductor code
   output logic [2:0] modeSelect // {autoskip, pfm, pwm}
);
   import bcc_pkg::*;

   localparam logic [12:0] VOLT_TAB [27] = '{
      13'h3e8, 13'h44c, 13'h4b0, 13'h4e2, 13'h514, 13'h546, 13'h5dc, 13'h640,
      13'h708, 13'h73a, 13'h7d0, 13'h834, 13'h866, 13'h8ca, 13'h8fc, 13'h960,
      13'h9c4, 13'haf0, 13'hc4e, 13'hc80, 13'hcb2, 13'hce4, 13'hd16, 13'hd48,
      13'hdac, 13'hed8, 13'hfa0};
   localparam logic [12:0] ILIM_TAB [4] = '{13'h834, 13'ha28, 13'hbb8, 13'h1194};
   localparam logic [10:0] IND_TAB [4] = '{11'h3e8, 11'h1d6, 11'h5dc, 11'h000};

   logic [12:0] mv_next, ma_next;
   logic [8:0] deg_next;
   logic [10:0] nh_next;
   logic rsv_next;
   logic [2:0] sel_next;

   // Table lookups
   always_comb begin
      mv_next = (voltCode > `BCC_VCODE_TOP) ? `BCC_VMAX_MV : VOLT_TAB[voltCode];
      ma_next = ILIM_TAB[ilimSel];
      deg_next = (phaseSel == `BCC_PHASE_ZERO) ? 9'h000 :
                 ({6'h00, phaseSel} + 9'h001) * `BCC_PHASE_STEP;
      nh_next = IND_TAB[inductorSel];
      rsv_next = (inductorSel == 2'h3);
      sel_next = 3'h0;
      case (modeCode)
         MODE_PWM: sel_next = 3'h1;
         MODE_PFM: sel_next = 3'h2;
         MODE_AUTOSKIP: sel_next = 3'h4;
         default: sel_next = 3'h0;
      endcase
   end

   // Output registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         setpointMv <= 13'h0000;
         currentLimitMa <= 13'h0000;
         phaseDeg <= 9'h000;
         inductorNh <= 11'h000;
         inductorReserved <= 1'b0;
         modeSelect <= 3'h0;
      end else begin
         setpointMv <= mv_next;
         currentLimitMa <= ma_next;
         phaseDeg <= deg_next;
         inductorNh <= nh_next;
         inductorReserved <= rsv_next;
         modeSelect <= sel_next;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   vmax_clamp_a: assert property (voltCode > 5'h1a |=> setpointMv == 13'h1004)
      else $error("high code not clamped to 4.10 V");
   vmin_point_a: assert property (rst_b && voltCode == 5'h00 |=> setpointMv == 13'h3e8)
      else $error("code 0 not 1.00 V");
   ilim_top_a: assert property (ilimSel == 2'h3 |=> currentLimitMa == 13'h1194)
      else $error("limit code 3 not 4.5 A");
   phase_zero_a: assert property (phaseSel == 3'h7 |=> phaseDeg == 9'h000)
      else $error("phase code 7 not zero");
   phase_step_a: assert property (phaseSel == 3'h3 |=> phaseDeg == 9'h0b4)
      else $error("phase code 3 not 180 degrees");
   ind_rsvd_a: assert property (inductorSel == 2'h3 |=> inductorReserved)
      else $error("reserved inductor code not flagged");
   mode_sel_a: assert property (modeCode == MODE_PFM |=> modeSelect == 3'h2)
      else $error("PFM code not selecting PFM");
endmodule

/* bcc_host_model.sv */
/*
 Host model: register bus master for the buck channel block.
 Assumes one core_clk and read data in the cycle after the read strobe.
*/
`timescale 1ns/100ps
module bcc_host_model (
   input logic core_clk, // Core clock
   output logic [3:0] regAddr, // Register address
   output logic [7:0] regWdata, // Write data
   output logic regWr, // Write strobe
   output logic regRd, // Read strobe
   input logic [7:0] regRdata // Read data
);
   // Idle bus; released lines are inverted so stale values never look valid
   initial begin
      regAddr = 4'h0;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge core_clk);
      regWr <= 1'b0;
      regAddr <= ~a;
      regWdata <= ~d;
   endtask
   // One-cycle read strobe, data taken at the following edge
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge core_clk);
      regRd <= 1'b0;
      regAddr <= ~a;
      @(posedge core_clk);
      d = regRdata;
   endtask
endmodule

/* buck_regulator_config_control_tb.sv */
/*
 Self-checking bench for bcc_ctrl: random OTP defaults and codes, corner cases.
 Assumes the host model drives the register bus; pins are driven here.
*/
`timescale 1ns/100ps
`include "bcc_cfg.svh"
module buck_regulator_config_control_tb;
   import bcc_pkg::*;
   localparam int DISCH = 20;
   logic core_clk, rst_b, regWr, regRd, otpInPowerUpSeq, standbyPin, systemOnPin;
   logic regEnable, dischargeEn, inductorReserved, irqOutN;
   logic [3:0] regAddr;
   logic [7:0] regWdata, regRdata, rv, wv;
   logic [4:0] otpOutVoltageDefault, v;
   logic [2:0] otpPhaseDefault, modeSelect;
   logic [1:0] otpInductorSel;
   bcc_mode_t regulatorModeCode;
   logic [12:0] setpointMv, currentLimitMa;
   logic [8:0] phaseDeg;
   logic [10:0] inductorNh;
   logic [31:0] seed = 32'hfdf7eddb;
   int n_mismatch = 0, checked = 0, k, n;
   int mvTab[27] = '{1000, 1100, 1200, 1250, 1300, 1350, 1500, 1600, 1800, 1850, 2000,
      2100, 2150, 2250, 2300, 2400, 2500, 2800, 3150, 3200, 3250, 3300, 3350, 3400, 3500,
      3800, 4000};
   int limTab[4] = '{2100, 2600, 3000, 4500};
   int indTab[4] = '{1000, 470, 1500, 0};

   bcc_ctrl #(.DISCH_CYCLES(DISCH)) dut (.core_clk, .rst_b, .regAddr, .regWdata, .regWr,
      .regRd, .regRdata, .otpOutVoltageDefault, .otpPhaseDefault, .otpInductorSel,
      .otpInPowerUpSeq, .standbyPin, .systemOnPin, .regEnable, .dischargeEn,
      .regulatorModeCode, .modeSelect, .setpointMv, .currentLimitMa, .phaseDeg,
      .inductorNh, .inductorReserved, .irqOutN);
   bcc_host_model host (.core_clk, .regAddr, .regWdata, .regWr, .regRd, .regRdata);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xorshift();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [15:0] expMv(input logic [4:0] c);
      return (c > 5'h1a) ? 16'h1004 : 16'(mvTab[c]);
   endfunction
   task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkOut(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask
   // Pins pass a filter of a few cycles, so settle generously
   task automatic pins(input logic sb, input logic so);
      @(posedge core_clk);
      standbyPin <= sb;
      systemOnPin <= so;
      cyc(8);
   endtask
   task automatic tally_and_finish();
      $display("checked=%0d mismatches=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Core clock, 40 ns
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_b = 1'b0;
      standbyPin = 1'b0;
      systemOnPin = 1'b0;
      otpInPowerUpSeq = 1'b1;
      {otpOutVoltageDefault, otpPhaseDefault, otpInductorSel} = 10'(xorshift());
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      cyc(6);
      host.rd(`BCC_ADDR_VOLT, rv);
      chkReg(rv, {3'h0, otpOutVoltageDefault});
      host.rd(`BCC_ADDR_MODE, rv);
      chkReg(rv, 8'h0f);
      host.rd(`BCC_ADDR_CFG, rv);
      chkReg(rv, {3'h0, otpPhaseDefault, 2'h0});
      chkOut(16'(inductorNh), 16'(indTab[otpInductorSel]));
      chkOut(16'(inductorReserved), 16'(otpInductorSel == 2'h3));
      chkOut(16'(regulatorModeCode), 16'h0003);
      chkOut(16'(irqOutN), 16'h0000);
      host.wr(`BCC_ADDR_STATUS, 8'hff);
      host.rd(`BCC_ADDR_STATUS, rv);
      chkReg(rv, {1'b0, otpInductorSel, 5'h03});
      host.wr(4'h9, 8'h5a);
      host.rd(4'h9, rv);
      chkReg(rv, 8'h00);
      host.wr(`BCC_ADDR_IRQ_STAT, 8'h03);
      cyc(2);
      chkOut(16'(irqOutN), 16'h0001);
      $display("test defaults done");
      // Every voltage code while off
      for (k = 0; k < 32; k++) begin
         host.wr(`BCC_ADDR_VOLT, 8'(k));
         cyc(4);
         chkOut(16'(setpointMv), expMv(5'(k)));
      end
      // Every current limit and phase code, then a random readback
      for (k = 0; k < 32; k++) begin
         host.wr(`BCC_ADDR_CFG, 8'(k));
         cyc(4);
         chkOut(16'(currentLimitMa), 16'(limTab[k % 4]));
         chkOut(16'(phaseDeg), (k / 4 == 7) ? 16'h0000 : 16'(45 * (k / 4 + 1)));
      end
      wv = 8'(xorshift());
      host.wr(`BCC_ADDR_CFG, wv);
      host.rd(`BCC_ADDR_CFG, rv);
      chkReg(rv, wv & 8'h1f);
      $display("test decode done");
      // Each run mode while on, interrupt masked on odd passes
      pins(1'b0, 1'b1);
      for (k = 0; k < 4; k++) begin
         host.wr(`BCC_ADDR_IRQ_MASK, (k % 2) ? 8'h03 : 8'h00);
         host.wr(`BCC_ADDR_MODE, 8'(k));
         cyc(4);
         chkOut(16'(regulatorModeCode), 16'(k));
         chkOut(16'(modeSelect), (k == 0) ? 16'h0000 : 16'(1 << (k - 1)));
         chkOut(16'(regEnable), 16'(k != 0));
         chkOut(16'(irqOutN), 16'(k % 2));
         host.rd(`BCC_ADDR_IRQ_STAT, rv);
         chkReg(rv & 8'h01, 8'h01);
         host.wr(`BCC_ADDR_IRQ_STAT, 8'h03);
      end
      $display("test modes done");
      // Run to standby keeps the output, standby off disables it
      host.wr(`BCC_ADDR_MODE, 8'h09);
      pins(1'b1, 1'b1);
      chkOut(16'(regulatorModeCode), 16'h0002);
      chkOut(16'(setpointMv), expMv(5'h1f));
      chkOut(16'(regEnable), 16'h0001);
      chkOut(16'(dischargeEn), 16'h0000);
      host.wr(`BCC_ADDR_MODE, 8'h01);
      cyc(4);
      chkOut(16'(regEnable), 16'h0000);
      pins(1'b0, 1'b1);
      chkOut(16'(regEnable), 16'h0001);
      $display("test standby done");
      // Code change while on: discharge, then restart at the new level
      v = 5'(xorshift());
      if (v == 5'h1f) v = 5'h00;
      host.wr(`BCC_ADDR_VOLT, {3'h0, v});
      for (n = 0; n < 10 && dischargeEn !== 1'b1; n++) cyc(1);
      if (n == 10) begin
         n_mismatch++;
         tally_and_finish();
      end
      chkOut(16'(regEnable), 16'h0000);
      chkOut(16'(setpointMv), expMv(5'h1f));
      for (n = 0; n < 100 && regEnable !== 1'b1; n++) cyc(1);
      chkOut(16'(n), 16'(DISCH));
      cyc(2);
      chkOut(16'(setpointMv), expMv(v));
      host.rd(`BCC_ADDR_IRQ_STAT, rv);
      chkReg(rv & 8'h02, 8'h02);
      $display("test restart done");
      // Second reset with the channel left out of the power-up sequence
      rst_b <= 1'b0;
      otpInPowerUpSeq <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      cyc(6);
      host.rd(`BCC_ADDR_MODE, rv);
      chkReg(rv, 8'h00);
      chkOut(16'(regulatorModeCode), 16'h0000);
      chkOut(16'(regEnable), 16'h0000);
      chkOut(16'(irqOutN), 16'h0001);
      $display("test reset done");
      tally_and_finish();
   end
endmodule
